// file: core/pd_seq_params.svh
`ifndef PD_SEQ_PARAMS_SVH
`define PD_SEQ_PARAMS_SVH
`define QUAL_TIME_NS 150000
`define CLK_PERIOD_NS 8
`define QUAL_CYCLES (`QUAL_TIME_NS / `CLK_PERIOD_NS)
`define QUAL_CNT_W 16
`endif

// file: core/pd_seq_pkg.sv
package pd_seq_pkg;
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_INRUSH = 3'b010,
    ST_OPER = 3'b100
  } lim_state_t;
  typedef struct packed {
    logic above_line_undervoltage_lockout_on;
    logic below_line_undervoltage_lockout_off;
    logic in_det_range;
    logic in_class_range;
    logic below_class_low;
    logic inrush_settled;
    logic switch_over_10v;
    logic rail_over_10v;
  } cmp_t;
  typedef struct packed {
    logic switch_en;
    logic inrush_limit;
    logic pg_pull_low;
    logic sig_connect;
    logic class_en;
    logic inrush_set_en;
  } ctl_t;
endpackage

// file: core/qual_timer.sv
`include "pd_seq_params.svh"
module qual_timer #(
  parameter int CYCLES = `QUAL_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_cond,
  output logic o_done
);
  logic [`QUAL_CNT_W-1:0] cnt;
  localparam logic [`QUAL_CNT_W-1:0] LAST = `QUAL_CNT_W'(CYCLES - 1);
  // restart whenever qualifying condition drops
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cnt <= '0;
    end else if (i_ce) begin
      if (!i_cond) begin
        cnt <= '0;
      end else if (cnt != LAST) begin
        cnt <= cnt + `QUAL_CNT_W'(1);
      end
    end
  end
  assign o_done = i_cond && (cnt == LAST);
endmodule

// file: core/pd_hotswap_seq.sv
// Functional notes
// - below lower lockout: reset, switch off
// - above turn-on: enable switch at inrush limit
// - settled 150us: operational limit, release good
// - switch over 10V 150us: fold back
// - good low when off in class range, inrush, rail high
// - detection mode below class threshold
// - idle mode: all nodes high impedance
// - class current only within class range
// - signature connected only in detect range
`include "pd_seq_params.svh"
module pd_hotswap_seq #(
  parameter int QUAL_CYCLES = `QUAL_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire pd_seq_pkg::cmp_t i_cmp,
  output pd_seq_pkg::ctl_t o_ctl,
  output logic o_supply_ok_output_oe,
  output logic o_supply_ok_output
);
  pd_seq_pkg::cmp_t cmp_meta;
  pd_seq_pkg::cmp_t cmp;
  pd_seq_pkg::lim_state_t state;
  pd_seq_pkg::lim_state_t next_state;
  pd_seq_pkg::ctl_t next_ctl;
  logic settled_done;
  logic fold_done;

  // shared by the output decode and the checks
  function automatic logic powered(input pd_seq_pkg::lim_state_t s);
    return s != pd_seq_pkg::ST_OFF;
  endfunction

  // comparator outputs are asynchronous to i_clk
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cmp_meta <= '0;
      cmp <= '0;
    end else if (i_ce) begin
      cmp_meta <= i_cmp;
      cmp <= cmp_meta;
    end
  end

  qual_timer #(.CYCLES(QUAL_CYCLES)) u_settle (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_cond(state == pd_seq_pkg::ST_INRUSH && cmp.inrush_settled),
    .o_done(settled_done)
  );

  qual_timer #(.CYCLES(QUAL_CYCLES)) u_fold (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_cond(state == pd_seq_pkg::ST_OPER && cmp.switch_over_10v),
    .o_done(fold_done)
  );

  always_comb begin
    next_state = state;
    case (state)
      pd_seq_pkg::ST_OFF: begin
        if (cmp.above_line_undervoltage_lockout_on && !cmp.below_line_undervoltage_lockout_off) begin
          next_state = pd_seq_pkg::ST_INRUSH;
        end
      end
      pd_seq_pkg::ST_INRUSH: begin
        if (settled_done) begin
          next_state = pd_seq_pkg::ST_OPER;
        end
      end
      pd_seq_pkg::ST_OPER: begin
        if (fold_done) begin
          next_state = pd_seq_pkg::ST_INRUSH;
        end
      end
      default: next_state = pd_seq_pkg::ST_OFF;
    endcase
    // lockout overrides every other transition
    if (cmp.below_line_undervoltage_lockout_off) begin
      next_state = pd_seq_pkg::ST_OFF;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state <= pd_seq_pkg::ST_OFF;
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  // plain run lengths of each qualifying condition, kept apart from the
  // timers so the interval checks do not lean on the timers themselves
  logic [`QUAL_CNT_W-1:0] settle_run;
  logic [`QUAL_CNT_W-1:0] fold_run;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      settle_run <= '0;
    end else if (i_ce) begin
      if (!(state == pd_seq_pkg::ST_INRUSH && cmp.inrush_settled)) begin
        settle_run <= '0;
      end else if (settle_run != '1) begin
        settle_run <= settle_run + `QUAL_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      fold_run <= '0;
    end else if (i_ce) begin
      if (!(state == pd_seq_pkg::ST_OPER && cmp.switch_over_10v)) begin
        fold_run <= '0;
      end else if (fold_run != '1) begin
        fold_run <= fold_run + `QUAL_CNT_W'(1);
      end
    end
  end

  // outputs registered from the next state so they track it exactly
  always_comb begin
    next_ctl = '0;
    next_ctl.switch_en = powered(next_state);
    next_ctl.inrush_limit = next_state == pd_seq_pkg::ST_INRUSH;
    next_ctl.pg_pull_low = !cmp.below_class_low &&
      (next_state != pd_seq_pkg::ST_OPER || cmp.rail_over_10v);
    // detection leaves good released and node to negative rail
    next_ctl.sig_connect = cmp.below_class_low && cmp.in_det_range;
    next_ctl.class_en = !cmp.below_class_low && cmp.in_class_range &&
      next_state == pd_seq_pkg::ST_OFF;
    next_ctl.inrush_set_en = !cmp.below_class_low &&
      powered(next_state);
    // idle: off, above class range, so all of the above stay low
    if (next_state == pd_seq_pkg::ST_OFF && !cmp.in_class_range) begin
      next_ctl.pg_pull_low = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_ctl <= '0;
    end else if (i_ce) begin
      o_ctl <= next_ctl;
    end
  end

  assign o_supply_ok_output = 1'b0;
  assign o_supply_ok_output_oe = o_ctl.pg_pull_low;

  a_lockout_off: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    i_ce && cmp.below_line_undervoltage_lockout_off |=> !o_ctl.switch_en)
    else $error("switch on under lockout");
  a_turn_on_inrush: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    i_ce && state == pd_seq_pkg::ST_OFF &&
    next_state == pd_seq_pkg::ST_INRUSH
    |=> o_ctl.switch_en && o_ctl.inrush_limit)
    else $error("turn on not at inrush");
  a_settle_time: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    i_ce && state == pd_seq_pkg::ST_INRUSH &&
    next_state == pd_seq_pkg::ST_OPER
    |-> settle_run == `QUAL_CNT_W'(QUAL_CYCLES - 1))
    else $error("operational entered early");
  a_oper_release: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    i_ce && state == pd_seq_pkg::ST_INRUSH &&
    next_state == pd_seq_pkg::ST_OPER && !cmp.rail_over_10v
    |=> !o_ctl.inrush_limit && !o_supply_ok_output_oe)
    else $error("good held after settling");
  a_fold_back: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    i_ce && fold_done && !cmp.below_line_undervoltage_lockout_off
    |=> state == pd_seq_pkg::ST_INRUSH)
    else $error("no fold back");
  a_fold_time: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    i_ce && state == pd_seq_pkg::ST_OPER &&
    next_state == pd_seq_pkg::ST_INRUSH
    |-> fold_run == `QUAL_CNT_W'(QUAL_CYCLES - 1))
    else $error("fold back before full interval");
  a_good_low: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    i_ce && cmp.rail_over_10v && !cmp.below_class_low &&
    powered(next_state)
    |=> o_supply_ok_output_oe)
    else $error("good released with rail high");
  a_inrush_pg: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    $past(i_ce) && o_ctl.inrush_limit && !$past(cmp.below_class_low)
    |-> o_supply_ok_output_oe)
    else $error("good released during inrush");
  a_det_nodes: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    $past(i_ce) && $past(cmp.below_class_low) |->
    !o_ctl.class_en && !o_ctl.inrush_set_en && !o_supply_ok_output_oe)
    else $error("detection mode nodes wrong");
  a_idle_nodes: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    i_ce && next_state == pd_seq_pkg::ST_OFF && !cmp.in_class_range &&
    !cmp.below_class_low
    |=> !o_supply_ok_output_oe && !o_ctl.sig_connect && !o_ctl.class_en &&
    !o_ctl.switch_en)
    else $error("idle mode nodes not released");
  a_sig_range: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    $past(i_ce) && o_ctl.sig_connect |-> $past(cmp.in_det_range))
    else $error("signature outside range");
  a_class_range: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    $past(i_ce) && o_ctl.class_en |-> $past(cmp.in_class_range))
    else $error("class outside range");
  a_ce_freeze: assert property (@(posedge i_clk)
    disable iff (!i_reset_n)
    !i_ce |=> $stable(o_ctl) && $stable(state))
    else $error("state moved while clock enable low");

  c_power_up: cover property (@(posedge i_clk)
    state == pd_seq_pkg::ST_INRUSH ##1 state == pd_seq_pkg::ST_OPER);
  c_fold: cover property (@(posedge i_clk)
    state == pd_seq_pkg::ST_OPER ##1 state == pd_seq_pkg::ST_INRUSH);
  c_lockout: cover property (@(posedge i_clk)
    state == pd_seq_pkg::ST_OPER ##1 state == pd_seq_pkg::ST_OFF);
  c_class: cover property (@(posedge i_clk) o_ctl.class_en);
  c_settle_restart: cover property (@(posedge i_clk)
    settle_run != '0 ##1
    (settle_run == '0 && state == pd_seq_pkg::ST_INRUSH));
endmodule

// file: tb/pse_model.sv
// sourcing side: turns the line voltage it applies into comparator levels
module pse_model #(
  parameter int UV_ON_MV = 39500,
  parameter int UV_OFF_MV = 30000
) (
  input wire logic [15:0] i_line_mv,
  input wire logic [2:0] i_load,
  output pd_seq_pkg::cmp_t o_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  // probes stay within 2.7..10.1 V, 1 V apart; power off = 0 V
  assign o_cmp.above_line_undervoltage_lockout_on = i_line_mv >= 16'(UV_ON_MV);
  assign o_cmp.below_line_undervoltage_lockout_off = i_line_mv < 16'(UV_OFF_MV);
  assign o_cmp.in_det_range = i_line_mv >= 16'd1400 && i_line_mv <= 16'd11300;
  assign o_cmp.in_class_range = i_line_mv >= 16'd13000
    && i_line_mv <= 16'd21000;
  assign o_cmp.below_class_low = i_line_mv < 16'd13000;
  assign o_cmp.inrush_settled = i_load[2];
  assign o_cmp.switch_over_10v = i_load[1];
  assign o_cmp.rail_over_10v = i_load[0];
endmodule

// file: tb/poe_pd_hotswap_sequencer_bench.sv
module poe_pd_hotswap_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [15:0] line_mv = 16'h0000;
  logic [2:0] load = 3'h0;
  logic ce = 1'b1;
  pd_seq_pkg::cmp_t cmp;
  pd_seq_pkg::ctl_t ctl;
  logic oe;
  logic od;
  int bad_count = 0;
  int checks_done = 0;
  initial forever #4 i_clk = ~i_clk;
  pse_model pse (.i_line_mv(line_mv), .i_load(load), .o_cmp(cmp));
  pd_hotswap_seq #(.QUAL_CYCLES(8)) DUT (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_ce(ce), .i_cmp(cmp), .o_ctl(ctl),
    .o_supply_ok_output_oe(oe), .o_supply_ok_output(od));
  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // bit7 good data, bit6 good enable, then ctl msb first
  task automatic expect_out(string name, logic [7:0] m, logic [7:0] e,
                            int bound);
    logic [7:0] seen;
    checks_done++;
    for (int i = 0; i < bound; i++) begin
      @(posedge i_clk);
      #1;
      seen = {od, oe, ctl};
      if ((seen & m) === e) return;
    end
    bad_count++;
    $display("[FAIL] %s expected %h seen %h", name, e, seen & m);
    print_verdict();
  endtask
  task automatic drive(logic [15:0] mv, logic [2:0] ld);
    @(posedge i_clk);
    line_mv <= mv;
    load <= ld;
  endtask
  task automatic detect_class_idle();
    drive(16'h1388, 3'h0);
    expect_out("detect", 8'hff, 8'h04, 12);
    drive(16'h2ee0, 3'h0);
    expect_out("gap", 8'h04, 8'h00, 12);
    drive(16'h4650, 3'h0);
    expect_out("class", 8'hff, 8'h4a, 12);
    drive(16'h61a8, 3'h0);
    expect_out("idle", 8'hff, 8'h00, 12);
  endtask
  task automatic power_and_settle();
    drive(16'hbb80, 3'h0);
    expect_out("inrush", 8'hf8, 8'h78, 12);
    drive(16'hbb80, 3'h4);
    repeat (5) @(posedge i_clk);
    load <= 3'h0;
    @(posedge i_clk);
    load <= 3'h4;
    repeat (4) @(posedge i_clk);
    expect_out("restart", 8'h18, 8'h18, 1);
    expect_out("oper", 8'hf8, 8'h20, 20);
  endtask
  task automatic faults_and_dropout();
    drive(16'hbb80, 3'h5);
    expect_out("rail", 8'h48, 8'h48, 12);
    drive(16'hbb80, 3'h4);
    expect_out("rail_ok", 8'h48, 8'h00, 12);
    drive(16'hbb80, 3'h2);
    expect_out("foldback", 8'h30, 8'h30, 24);
    drive(16'h4e20, 3'h0);
    expect_out("dropout", 8'h70, 8'h40, 12);
    drive(16'h0000, 3'h0);
    expect_out("removed", 8'hff, 8'h00, 12);
  endtask
  // a lockout level while frozen must not reach the state
  task automatic freeze_hold();
    @(posedge i_clk);
    ce <= 1'b0;
    line_mv <= 16'h4e20;
    repeat (6) @(posedge i_clk);
    expect_out("frozen", 8'hf8, 8'h20, 1);
    @(posedge i_clk);
    line_mv <= 16'hbb80;
    @(posedge i_clk);
    ce <= 1'b1;
    expect_out("thawed", 8'hf8, 8'h20, 12);
  endtask
  initial begin
    expect_out("reset", 8'hff, 8'h00, 1);
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    detect_class_idle();
    power_and_settle();
    freeze_hold();
    faults_and_dropout();
    print_verdict();
  end
endmodule
